// ==== bench/batch_buffer_start_decode_bench.sv ====
// self-checking bench for the batch-start decoder
// assumes the fetch model in bbs_fetch_model and one 100 MHz clock
module batch_buffer_start_decode_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [31:0] cmd_data = 32'h0000_0000;
   logic cmd_valid = 1'b0;
   logic slow = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic cmd_ready, exec_valid, exec_ready, fetch_start, fetch_per_process_translation_space, fetch_return;
   logic fetch_qword, batch_active, cmd_denied, avs_waitrequest, st_pp;
   logic [31:0] exec_data, fetch_addr, avs_readdata, st_addr, rd;
   logic [31:0] got_q[$];
   logic [31:0] exp_q[$];
   int n_mismatch, samples_checked, n_start, n_ret, n_den;

   always #5 clk_sys = ~clk_sys;

   bbs_batch_start_decode dut (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_data(cmd_data),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .exec_data(exec_data),
      .exec_valid(exec_valid), .exec_ready(exec_ready), .fetch_start(fetch_start),
      .fetch_addr(fetch_addr), .fetch_per_process_translation_space(fetch_per_process_translation_space), .fetch_return(fetch_return),
      .fetch_qword(fetch_qword), .batch_active(batch_active), .cmd_denied(cmd_denied),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   bbs_fetch_model #(.NQ(3)) far (.clk_sys(clk_sys), .arst_n(arst_n),
      .fetch_start(fetch_start), .fetch_return(fetch_return), .slow(slow),
      .fetch_qword(fetch_qword), .exec_ready(exec_ready));

   always @(posedge clk_sys)
   begin
      if (exec_valid && exec_ready)
         got_q.push_back(exec_data);
      if (fetch_start)
      begin
         n_start++;
         st_addr = fetch_addr;
         st_pp = fetch_per_process_translation_space;
      end
      if (fetch_return)
         n_ret++;
      if (cmd_denied)
         n_den++;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   // valid stays high between back-to-back dwords; settle drops it
   task automatic send(input logic [31:0] w, input logic fwd);
      logic ok;
      cmd_data <= w;
      cmd_valid <= 1'b1;
      if (fwd)
         exp_q.push_back(w);
      for (int i = 0; i < 100; i++)
      begin
         @(negedge clk_sys);
         ok = cmd_ready;
         @(posedge clk_sys);
         if (ok)
            break;
      end
      // a dword never taken is a failure, not a silent skip
      if (!ok)
         n_mismatch++;
   endtask

   task automatic pkt(input logic [31:0] h, input int n, input logic fwd);
      send(h, fwd);
      for (int i = 0; i < n; i++)
         send(32'h00a0_0000 | 32'(i), fwd);
   endtask

   task automatic settle();
      cmd_valid <= 1'b0;
      for (int i = 0; i < 100; i++)
      begin
         @(negedge clk_sys);
         if (exec_valid === 1'b0)
            break;
      end
      repeat (4) @(posedge clk_sys);
      chk(32'(got_q.size()), 32'(exp_q.size()));
      for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
         chk(got_q[i], exp_q[i]);
      got_q.delete();
      exp_q.delete();
   endtask

   // request held until the edge that sees waitrequest low; only the watchdog ends a hang
   task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      do
      begin
         @(posedge clk_sys);
      end
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      acc(1'b0, bbs_pkg::REG_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      acc(1'b0, bbs_pkg::REG_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      acc(1'b1, bbs_pkg::REG_HEAD_LO, 32'hffff_ffff);
      acc(1'b0, bbs_pkg::REG_HEAD_LO, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      acc(1'b0, bbs_pkg::REG_HEAD_HI, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      acc(1'b0, 4'h2, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      acc(1'b1, bbs_pkg::REG_CTRL, 32'h0000_0000);
      @(negedge clk_sys);
      chk(cmd_ready, 32'h0000_0000);
      @(posedge clk_sys);
      acc(1'b1, bbs_pkg::REG_CTRL, 32'h0000_0001);
      $display("test regs done");
   endtask

   task automatic t_ring();
      send(32'h5880_0000, 1'b1);
      send(32'h0000_0000, 1'b1);
      send(32'h0500_0000, 1'b0);
      pkt(32'h1100_0001, 2, 1'b1);
      settle();
      chk(32'(n_start), 32'h0000_0000);
      chk(32'(n_ret), 32'h0000_0000);
      $display("test ring done");
   endtask

   task automatic t_secure();
      // low address bits kept zero, buffer stays inside one page
      send(32'h1880_0000, 1'b0);
      send(32'h0001_2340, 1'b0);
      pkt(32'h1100_0001, 2, 1'b1);
      settle();
      chk(32'(n_start), 32'h0000_0001);
      chk(st_addr, 32'h0001_2340);
      chk(st_pp, 32'h0000_0000);
      chk(32'(n_den), 32'h0000_0000);
      acc(1'b0, bbs_pkg::REG_HEAD_LO, 32'h0000_0000);
      chk(rd, 32'h0001_2359);
      send(32'h0500_0000, 1'b0);
      settle();
      chk(32'(n_ret), 32'h0000_0001);
      chk(batch_active, 32'h0000_0000);
      acc(1'b0, bbs_pkg::REG_HEAD_LO, 32'h0000_0000);
      chk(rd & 32'h0000_0001, 32'h0000_0000);
      $display("test secure done");
   endtask

   task automatic t_nonsec();
      slow <= 1'b1;
      // per-process translation taken as enabled here
      pkt(32'h1880_0101, 2, 1'b0);
      pkt(32'h1100_0001, 2, 1'b0);
      pkt(32'h1000_0001, 2, 1'b1);
      pkt(32'h1040_0001, 2, 1'b0);
      pkt(32'h1880_0000, 1, 1'b0);
      pkt(32'h1100_0001, 2, 1'b0);
      send(32'h0000_0000, 1'b1);
      settle();
      chk(32'(n_den), 32'h0000_0003);
      chk(st_pp, 32'h0000_0001);
      chk(st_addr, 32'h00a0_0000);
      acc(1'b0, bbs_pkg::REG_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0007);
      acc(1'b1, bbs_pkg::REG_STATUS, 32'h0000_0004);
      acc(1'b0, bbs_pkg::REG_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      send(32'h0500_0000, 1'b0);
      pkt(32'h1100_0001, 2, 1'b1);
      settle();
      chk(32'(n_ret), 32'h0000_0002);
      chk(32'(n_den), 32'h0000_0003);
      slow <= 1'b0;
      $display("test nonsecure done");
   endtask

   initial
   begin
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_ring();
      t_secure();
      t_nonsec();
      end_sim();
   end

   // the whole run needs a few hundred cycles; this is far beyond it
   initial
   begin
      #200us;
      n_mismatch++;
      end_sim();
   end
endmodule // batch_buffer_start_decode_bench

// ==== bench/bbs_fetch_model.sv ====
// far-side fetcher and downstream consumer model for the batch-start decoder
// assumes fetch_start and fetch_return are one-cycle pulses on clk_sys
module bbs_fetch_model
#(
   parameter int NQ = 3
)
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic fetch_start,
   input wire logic fetch_return,
   input wire logic slow,
   output logic fetch_qword,
   output logic exec_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;

   // ------------------------------------------------------------
   // qword fetch pulses, then a stalling consumer
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt <= 0;
         fetch_qword <= 1'b0;
         exec_ready <= 1'b0;
      end
      else
      begin
         // a return abandons what is left of the batch fetch
         if (fetch_start)
            cnt <= NQ;
         else if (fetch_return)
            cnt <= 0;
         else if (cnt > 0)
            cnt <= cnt - 1;
         fetch_qword <= (cnt > 0) && !fetch_start && !fetch_return;
         exec_ready <= slow ? !exec_ready : 1'b1;
      end
   end
endmodule // bbs_fetch_model

// ==== src/bbs_batch_start_decode.sv ====
// batch-start decode: parses the command stream, starts and ends batches
// assumes the fetcher drops prefetched dwords when fetch_start or fetch_return pulses
//
// Overview of operation
// - only command type 0 in header bits 31:29 is a memory-interface command
// - opcode 31h in bits 28:23 starts a batch buffer fetch
// - second dword bits 31:2 give the batch start address
// - security bit one on initial start: non-secure, per-process space, privileges denied
// - security bit zero on initial start: secure, global translation space
// - chained start ignores its security bit and inherits the first buffer's
// - store-immediate to per-process memory stays allowed in non-secure batches
// - batch-end opcode 0Ah inside a batch stops that batch
// - readable qword head pointer of the latest batch with a valid flag
module bbs_batch_start_decode
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [31:0] cmd_data,
   input wire logic cmd_valid,
   output logic cmd_ready,
   output logic [31:0] exec_data,
   output logic exec_valid,
   input wire logic exec_ready,
   output logic fetch_start,
   output logic [31:0] fetch_addr,
   output logic fetch_per_process_translation_space,
   output logic fetch_return,
   input wire logic fetch_qword,
   output logic batch_active,
   output logic cmd_denied,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      bbs_pkg::bbs_state_t st;
      logic [8:0] cnt;
      logic fwd;
      logic active;
      logic nonsec;
      logic out_valid;
      logic [31:0] out_data;
      logic fetch_start;
      logic [31:0] fetch_addr;
      logic fetch_per_process_translation_space;
      logic fetch_return;
      logic denied;
      logic denied_sticky;
      logic enable;
      logic ack;
      logic [31:0] rdata;
   } bbs_core_t;

   bbs_core_t s_q;
   bbs_core_t s_d;

   logic dec_mi;
   logic dec_start;
   logic dec_end;
   logic dec_store_ok;
   logic dec_priv;
   logic [8:0] dec_body;
   logic take;
   logic bus_req;
   logic hp_load;
   logic [31:3] hp_head;
   logic hp_valid;

   // ----------------------------------------------------------------
   // header decode and head pointer
   // ----------------------------------------------------------------
   bbs_hdr_decode u_dec
   (
      .hdr(cmd_data),
      .is_mi(dec_mi),
      .is_start(dec_start),
      .is_end(dec_end),
      .is_store_ok(dec_store_ok),
      .is_priv(dec_priv),
      .body_len(dec_body)
   );

   assign hp_load = take && (s_q.st == bbs_pkg::ST_ADDR);

   bbs_head_ptr u_hp
   (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .load(hp_load),
      .load_addr(cmd_data),
      .adv(fetch_qword),
      .clear(s_q.fetch_return),
      .head(hp_head),
      .valid(hp_valid)
   );

   function automatic logic [31:0] read_mux(input logic [3:0] a, input bbs_core_t s,
                                            input logic [31:3] head, input logic hv);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         bbs_pkg::REG_HEAD_LO:
         begin
            r[31:bbs_pkg::QW_LSB] = head;
            r[bbs_pkg::HEAD_VALID_BIT] = hv;
         end
         bbs_pkg::REG_CTRL: r[bbs_pkg::CTRL_ENABLE_BIT] = s.enable;
         bbs_pkg::REG_STATUS:
         begin
            r[bbs_pkg::STAT_ACTIVE_BIT] = s.active;
            r[bbs_pkg::STAT_NONSEC_BIT] = s.nonsec;
            r[bbs_pkg::STAT_DENIED_BIT] = s.denied_sticky;
         end
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // parser and register file
   // ----------------------------------------------------------------
   // one output slot; parser stalls whenever it is occupied and not drained
   assign cmd_ready = s_q.enable && (!s_q.out_valid || exec_ready);
   assign take = cmd_valid && cmd_ready;
   assign bus_req = avs_read || avs_write;

   always_comb
   begin
      s_d = s_q;
      s_d.fetch_start = 1'b0;
      s_d.fetch_return = 1'b0;
      s_d.denied = 1'b0;
      s_d.ack = 1'b0;
      if (s_q.out_valid && exec_ready)
      begin
         s_d.out_valid = 1'b0;
      end
      if (take)
      begin
         unique case (s_q.st)
            bbs_pkg::ST_HEAD:
            begin
               if (dec_start)
               begin
                  if (!s_q.active)
                  begin
                     s_d.nonsec = cmd_data[bbs_pkg::SEC_BIT];
                  end
                  // chained start keeps nonsec unchanged
                  s_d.cnt = {1'b0, cmd_data[bbs_pkg::LEN_MSB:bbs_pkg::LEN_LSB]};
                  s_d.fwd = 1'b0;
                  s_d.st = bbs_pkg::ST_ADDR;
               end
               else if (dec_end)
               begin
                  // a ring-level batch-end has nothing to stop
                  if (s_q.active)
                  begin
                     s_d.active = 1'b0;
                     s_d.fetch_return = 1'b1;
                  end
               end
               else
               begin
                  s_d.fwd = !(dec_priv && s_q.active && s_q.nonsec);
                  s_d.denied = !s_d.fwd;
                  if (s_d.fwd)
                  begin
                     s_d.out_valid = 1'b1;
                     s_d.out_data = cmd_data;
                  end
                  s_d.cnt = dec_body;
                  s_d.st = (dec_body != 9'h000) ? bbs_pkg::ST_BODY : bbs_pkg::ST_HEAD;
               end
            end
            bbs_pkg::ST_ADDR:
            begin
               // low two bits are reserved and dropped
               s_d.fetch_addr = {cmd_data[31:bbs_pkg::ADDR_LSB], 2'b00};
               s_d.fetch_start = 1'b1;
               s_d.fetch_per_process_translation_space = s_q.nonsec;
               s_d.active = 1'b1;
               s_d.st = (s_q.cnt != 9'h000) ? bbs_pkg::ST_BODY : bbs_pkg::ST_HEAD;
            end
            bbs_pkg::ST_BODY:
            begin
               if (s_q.fwd)
               begin
                  s_d.out_valid = 1'b1;
                  s_d.out_data = cmd_data;
               end
               s_d.cnt = s_q.cnt - 9'h001;
               if (s_q.cnt == 9'h001)
               begin
                  s_d.st = bbs_pkg::ST_HEAD;
               end
            end
            default: s_d.st = bbs_pkg::ST_HEAD;
         endcase
      end
      // bus: answer one cycle after the request appears
      if (bus_req && !s_q.ack)
      begin
         s_d.ack = 1'b1;
         s_d.rdata = read_mux(avs_address, s_q, hp_head, hp_valid);
      end
      if (s_q.ack && avs_write && avs_byteenable[0])
      begin
         if (avs_address == bbs_pkg::REG_CTRL)
         begin
            s_d.enable = avs_writedata[bbs_pkg::CTRL_ENABLE_BIT];
         end
         if ((avs_address == bbs_pkg::REG_STATUS) && avs_writedata[bbs_pkg::STAT_DENIED_BIT])
         begin
            s_d.denied_sticky = 1'b0;
         end
      end
      // a denial in the clearing cycle still lands
      if (s_d.denied)
      begin
         s_d.denied_sticky = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q <= '0;
         s_q.st <= bbs_pkg::ST_HEAD;
         s_q.enable <= bbs_pkg::CTRL_ENABLE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign exec_data = s_q.out_data;
   assign exec_valid = s_q.out_valid;
   assign fetch_start = s_q.fetch_start;
   assign fetch_addr = s_q.fetch_addr;
   assign fetch_per_process_translation_space = s_q.fetch_per_process_translation_space;
   assign fetch_return = s_q.fetch_return;
   assign batch_active = s_q.active;
   assign cmd_denied = s_q.denied;
   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = bus_req && !s_q.ack;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   logic head_take;
   assign head_take = take && (s_q.st == bbs_pkg::ST_HEAD);

   chk_type_gate: assert property (head_take && !dec_mi |=> s_q.st != bbs_pkg::ST_ADDR)
      else $error("non memory-interface header entered address phase");
   chk_start_decode: assert property (head_take && dec_start |=> s_q.st == bbs_pkg::ST_ADDR)
      else $error("batch-start header not decoded");
   chk_addr_capture: assert property (take && s_q.st == bbs_pkg::ST_ADDR |=> fetch_start
      && fetch_addr == {$past(cmd_data[31:2]), 2'b00} ##1 hp_valid && !fetch_start)
      else $error("start address not captured");
   chk_nonsec_select: assert property (head_take && dec_start && !s_q.active
      && cmd_data[bbs_pkg::SEC_BIT] ##1 take [*1] |=> fetch_per_process_translation_space)
      else $error("non-secure start not sent to per-process space");
   chk_secure_select: assert property (head_take && dec_start && !s_q.active
      && !cmd_data[bbs_pkg::SEC_BIT] ##1 take |=> !fetch_per_process_translation_space)
      else $error("secure start not sent to global space");
   chk_chain_inherit: assert property (head_take && dec_start && s_q.active
      |=> $stable(s_q.nonsec))
      else $error("chained start changed security");
   chk_priv_denied: assert property (head_take && dec_priv && s_q.active && s_q.nonsec
      |=> cmd_denied && !exec_valid ##1 s_q.denied_sticky)
      else $error("privileged command passed in non-secure batch");
   chk_store_allowed: assert property (head_take && dec_store_ok |=> !cmd_denied
      && exec_valid)
      else $error("per-process store-immediate refused");
   chk_end_return: assert property (head_take && dec_end && s_q.active
      |=> fetch_return && !batch_active ##1 !hp_valid)
      else $error("batch-end did not stop the batch");
   chk_length_count: assert property (head_take && dec_start
      |=> s_q.cnt == {1'b0, $past(cmd_data[7:0])})
      else $error("batch-start length not loaded");
   chk_bus_answer: assert property (bus_req && !s_q.ack |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");

   cov_nonsec_start: cover property (fetch_start && fetch_per_process_translation_space);
   cov_chained_start: cover property (head_take && dec_start && s_q.active);
   cov_denied_cmd: cover property (cmd_denied);
   cov_batch_end: cover property (fetch_return);
endmodule // bbs_batch_start_decode

// ==== src/bbs_hdr_decode.sv ====
// header classifier for the batch-start decode block
// assumes hdr is the first dword of a command, valid only when so marked
module bbs_hdr_decode
(
   input wire logic [31:0] hdr,
   output logic is_mi,
   output logic is_start,
   output logic is_end,
   output logic is_store_ok,
   output logic is_priv,
   output logic [8:0] body_len
);
   function automatic logic [5:0] opc_of(input logic [31:0] d);
      return d[bbs_pkg::OPC_MSB:bbs_pkg::OPC_LSB];
   endfunction

   function automatic logic opc_is(input logic [31:0] d, input logic [5:0] op);
      return (d[bbs_pkg::TYPE_MSB:bbs_pkg::TYPE_LSB] == bbs_pkg::TYPE_MEMORY_INTERFACE)
         && (opc_of(d) == op);
   endfunction

   logic long_cmd;

   always_comb
   begin
      is_mi = (hdr[bbs_pkg::TYPE_MSB:bbs_pkg::TYPE_LSB] == bbs_pkg::TYPE_MEMORY_INTERFACE);
      is_start = opc_is(hdr, bbs_pkg::OPC_BATCH_START);
      is_end = opc_is(hdr, bbs_pkg::OPC_BATCH_END);
      // store-immediate is only exempt from denial when it targets per-process space
      is_store_ok = opc_is(hdr, bbs_pkg::OPC_STORE_IMM) && !hdr[bbs_pkg::STORE_GLOBAL_BIT];
      is_priv = is_mi && !is_start && !is_end && !is_store_ok
         && !opc_is(hdr, bbs_pkg::OPC_NOOP);
      long_cmd = !is_mi || (opc_of(hdr) >= bbs_pkg::OPC_LONG_FIRST);
      // dwords after the header: length field plus bias minus the header
      body_len = long_cmd
         ? ({1'b0, hdr[bbs_pkg::LEN_MSB:bbs_pkg::LEN_LSB]} + bbs_pkg::LEN_BIAS_BODY)
         : 9'h000;
   end
endmodule // bbs_hdr_decode

// ==== src/bbs_head_ptr.sv ====
// qword head pointer of the batch buffer now being fetched
// assumes the fetcher pulses adv once per qword it fetches from the batch
module bbs_head_ptr
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [31:0] load_addr,
   input wire logic adv,
   input wire logic clear,
   output logic [31:3] head,
   output logic valid
);
   typedef struct packed {
      logic [31:3] head;
      logic valid;
   } bbs_hp_t;

   bbs_hp_t s_q;
   bbs_hp_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (clear)
      begin
         s_d.valid = 1'b0;
      end
      else if (load)
      begin
         s_d.head = load_addr[31:bbs_pkg::QW_LSB];
         s_d.valid = 1'b1;
      end
      else if (adv && s_q.valid)
      begin
         s_d.head = s_q.head + 29'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign head = s_q.head;
   assign valid = s_q.valid;
endmodule // bbs_head_ptr

// ==== src/bbs_pkg.sv ====
// constants shared by the batch-start decode block
// assumes a 32-bit command dword stream and a 32-bit avalon-mm slave port
package bbs_pkg;
   // ----------------------------------------------------------------
   // command header fields
   // ----------------------------------------------------------------
   localparam int TYPE_MSB = 31;
   localparam int TYPE_LSB = 29;
   localparam int OPC_MSB = 28;
   localparam int OPC_LSB = 23;
   localparam int SEC_BIT = 8;
   localparam int LEN_MSB = 7;
   localparam int LEN_LSB = 0;
   localparam int ADDR_LSB = 2;
   localparam int QW_LSB = 3;
   localparam int STORE_GLOBAL_BIT = 22;
   localparam logic [2:0] TYPE_MEMORY_INTERFACE = 3'h0;
   localparam logic [5:0] OPC_NOOP = 6'h00;
   localparam logic [5:0] OPC_BATCH_END = 6'h0a;
   localparam logic [5:0] OPC_BATCH_START = 6'h31;
   localparam logic [5:0] OPC_STORE_IMM = 6'h20;
   // memory-interface opcodes below this carry no length field
   localparam logic [5:0] OPC_LONG_FIRST = 6'h10;
   localparam logic [8:0] LEN_BIAS_BODY = 9'h001;

   // ----------------------------------------------------------------
   // register map, byte offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_HEAD_LO = 4'h0;
   localparam logic [3:0] REG_HEAD_HI = 4'h4;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic CTRL_ENABLE_RST = 1'b1;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_NONSEC_BIT = 1;
   localparam int STAT_DENIED_BIT = 2;
   localparam int HEAD_VALID_BIT = 0;

   typedef enum logic [1:0] {
      ST_HEAD = 2'b00,
      ST_ADDR = 2'b01,
      ST_BODY = 2'b10
   } bbs_state_t;
endpackage
